// *** include/pll_clk_consts.svh ***
`ifndef PLL_CLK_CONSTS_SVH
`define PLL_CLK_CONSTS_SVH

// ==========================================
// timing counts
`define PLLC_LOCK_PERIODS   8'h08
`define PLLC_PERIOD_MAX     8'hFF

// ==========================================
// field codes
`define PLLC_PHASE_W        3
`define PLLC_RATE_CNT       4
`define PLLC_MULT_ONE       8'h01
`define PLLC_PHASE_FULL     3'h7

`endif

// *** include/pll_clk_pkg.sv ***
`include "pll_clk_consts.svh"

package pll_clk_pkg;

	// ==========================================
	// lock tracking
	typedef enum logic [0:0] {
		LK_ACQUIRE,
		LK_LOCKED
	} lock_state_t;

	// ==========================================
	// rate codes: 0 = x1, 1 = x2, 2 = x4, 3 = x8
	typedef logic [1:0] rate_code_t;

	typedef struct packed {
		logic                         in_prev;
		logic [`PLLC_PHASE_W-1:0]     phase;
		logic [7:0]                   period_cnt;
		logic [7:0]                   match_cnt;
		lock_state_t                  lock_st;
		logic [5:0]                   cfg;
		logic [`PLLC_RATE_CNT-1:0]    clk_en;
		logic                         rate_or_lock;
		logic [7:0]                   vco_mult;
	} state_t;

endpackage : pll_clk_pkg

// *** verilog/interpolating_dac_pll_clocking.sv ***
`timescale 1ns/10ps
`default_nettype none

`include "pll_clk_consts.svh"

module interpolating_dac_pll_clocking #(
	parameter logic [7:0] LOCK_PERIODS = `PLLC_LOCK_PERIODS
) (
	input  wire logic                          i_clk_sys,
	input  wire logic                          i_sys_rst,
	input  wire logic                          i_converter_clock_input,
	input  wire logic                          i_pll_enable,
	input  wire pll_clk_pkg::rate_code_t       i_interp_sel,
	input  wire pll_clk_pkg::rate_code_t       i_prescale_sel,
	input  wire logic                          i_zero_stuff,
	output logic [`PLLC_RATE_CNT-1:0]          o_clk_en,
	output logic                               o_rate_clock_or_lock_output,
	output logic                               o_lock_status,
	output logic [7:0]                         o_vco_mult
);
	import pll_clk_pkg::*;

	// ==========================================
	// parameter check
	initial begin
		if (LOCK_PERIODS == 8'h00) begin
			$error("LOCK_PERIODS must be at least one");
		end
	end

	state_t s_q;
	state_t s_d;

	logic       in_rise;
	logic       tick;
	logic       cfg_change;
	logic [2:0] shift_amt;
	logic [5:0] cfg_now;
	logic [`PLLC_PHASE_W-1:0] phase_nx;
	logic [`PLLC_RATE_CNT-1:0] en_nx;

	assign in_rise    = i_converter_clock_input & ~s_q.in_prev;
	assign cfg_now    = {i_pll_enable, i_interp_sel, i_prescale_sel, i_zero_stuff};
	assign cfg_change = (cfg_now != s_q.cfg);
	// ratios are powers of two, so the product is one shift
	assign shift_amt  = 3'({1'b0, i_interp_sel}) + 3'({1'b0, i_prescale_sel})
		+ 3'({2'b00, i_zero_stuff});

	// ==========================================
	// fast tick and phase
	// with the PLL off every rising input edge is a converter sample; with it on the
	// system clock stands in for the VCO and the input edge realigns phase
	always_comb begin
		tick     = i_pll_enable ? 1'b1 : in_rise;
		phase_nx = s_q.phase;
		if (i_pll_enable && in_rise) begin
			phase_nx = '0;
		end else if (tick) begin
			phase_nx = s_q.phase + 3'h1;
		end
	end

	// ==========================================
	// aligned clock strobes, all taken from one counter so they never drift
	genvar k;
	generate
		for (k = 0; k < `PLLC_RATE_CNT; k++) begin : g_rate
			localparam logic [2:0] MASK = `PLLC_PHASE_FULL >> k;
			assign en_nx[k] = tick && ((phase_nx & MASK) == 3'h0);
		end
	endgenerate

	// ==========================================
	// next state
	always_comb begin
		s_d          = s_q;
		s_d.in_prev  = i_converter_clock_input;
		s_d.phase    = phase_nx;
		s_d.clk_en   = en_nx;
		s_d.cfg      = cfg_now;
		s_d.vco_mult = `PLLC_MULT_ONE << shift_amt;

		if (s_q.period_cnt != `PLLC_PERIOD_MAX) begin
			s_d.period_cnt = s_q.period_cnt + 8'h01;
		end
		if (in_rise) begin
			s_d.period_cnt = 8'h01;
			// one input period must span exactly the VCO ratio in fast ticks
			if (s_q.period_cnt == s_q.vco_mult) begin
				if (s_q.match_cnt != `PLLC_PERIOD_MAX) begin
					s_d.match_cnt = s_q.match_cnt + 8'h01;
				end
			end else begin
				s_d.match_cnt = 8'h00;
				s_d.lock_st   = LK_ACQUIRE;
			end
		end

		case (s_q.lock_st)
			LK_ACQUIRE: begin
				if (s_d.match_cnt >= LOCK_PERIODS) begin
					s_d.lock_st = LK_LOCKED;
				end
			end
			LK_LOCKED: begin
			end
			default: begin
				s_d.lock_st = LK_ACQUIRE;
			end
		endcase

		// any reconfiguration or a bypassed PLL drops lock
		if (cfg_change || !i_pll_enable) begin
			s_d.lock_st   = LK_ACQUIRE;
			s_d.match_cnt = 8'h00;
		end

		// pin shows lock with the PLL on, the 1x rate clock with it off
		if (i_pll_enable) begin
			s_d.rate_or_lock = (s_d.lock_st == LK_LOCKED);
		end else begin
			s_d.rate_or_lock = ~phase_nx[`PLLC_PHASE_W-1];
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================
	// outputs
	assign o_clk_en                    = s_q.clk_en;
	assign o_rate_clock_or_lock_output = s_q.rate_or_lock;
	// status has no write path at all, it only mirrors the lock state
	assign o_lock_status               = (s_q.lock_st == LK_LOCKED);
	assign o_vco_mult                  = s_q.vco_mult;

endmodule : interpolating_dac_pll_clocking

`default_nettype wire

// *** verif/host_clk_source.sv ***
`timescale 1ns/10ps
`default_nettype none
// ====
// host clock source: frames only, idle low
module host_clk_source (
	input  wire logic i_clk_sys,
	input  wire logic i_run,
	output logic      o_clk
);
	initial o_clk = 1'b0;
	// period 2 keeps x2 /1 inside its rate window
	always @(posedge i_clk_sys) begin
		o_clk <= i_run ? ~o_clk : 1'b0;
	end
endmodule : host_clk_source
`default_nettype wire

// *** verif/pll_clk_properties.sv ***
`timescale 1ns/10ps
`default_nettype none
// ====
// port properties
module pll_clk_properties (
	input wire logic                    i_clk_sys,
	input wire logic                    i_sys_rst,
	input wire logic                    i_pll_enable,
	input wire pll_clk_pkg::rate_code_t i_interp_sel,
	input wire pll_clk_pkg::rate_code_t i_prescale_sel,
	input wire logic                    i_zero_stuff,
	input wire logic [3:0]              o_clk_en,
	input wire logic                    o_rate_clock_or_lock_output,
	input wire logic                    o_lock_status,
	input wire logic [7:0]              o_vco_mult
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);
	sequence s_on3; i_pll_enable [*3]; endsequence
	sequence s_off3; !i_pll_enable [*3]; endsequence
	a_vco_ratio: assert property (!i_sys_rst |=> o_vco_mult == 8'(1) << (4'($past(i_interp_sel))
		+ 4'($past(i_prescale_sel)) + 4'($past(i_zero_stuff)))) else $error("vco ratio wrong");
	a_stuff_even: assert property (!i_sys_rst && i_zero_stuff |=> !o_vco_mult[0] && o_vco_mult != 8'h00)
		else $error("zero stuff not doubled");
	a_off_nolock: assert property (s_off3 |-> !o_lock_status) else $error("lock with pll off");
	a_pin_lock: assert property (s_on3 |-> o_rate_clock_or_lock_output == o_lock_status)
		else $error("pin and status differ");
	a_lock_cause: assert property ($rose(o_lock_status) |-> $past(i_pll_enable, 2))
		else $error("lock without pll");
	a_strobe_nest: assert property (1 |-> (o_clk_en[2:0] & ~o_clk_en[3:1]) == 3'h0)
		else $error("strobes not aligned");
	a_fast_tick: assert property (s_on3 |-> o_clk_en[3]) else $error("fast strobe missing");
endmodule : pll_clk_properties
bind interpolating_dac_pll_clocking pll_clk_properties u_props (.i_clk_sys(i_clk_sys),
	.i_sys_rst(i_sys_rst), .i_pll_enable(i_pll_enable), .i_interp_sel(i_interp_sel),
	.i_prescale_sel(i_prescale_sel), .i_zero_stuff(i_zero_stuff), .o_clk_en(o_clk_en),
	.o_rate_clock_or_lock_output(o_rate_clock_or_lock_output), .o_lock_status(o_lock_status),
	.o_vco_mult(o_vco_mult));
`default_nettype wire

// *** verif/interpolating_dac_pll_clocking_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module interpolating_dac_pll_clocking_tb_top;
	import pll_clk_pkg::*;
	logic        clk = 1'b0, rst = 1'b1, pll = 1'b0, zs = 1'b0, run = 1'b0, cin, pin, lk;
	rate_code_t  it = 2'h0, ps = 2'h0;
	logic [3:0]  en;
	logic [7:0]  vco, cnt [4];
	logic [31:0] seed = 32'hfe94_f2af;
	int          miscompares = 0, n_tests = 0, hi;
	always #12.5 clk = ~clk;
	host_clk_source u_src (.i_clk_sys(clk), .i_run(run), .o_clk(cin));
	interpolating_dac_pll_clocking #(.LOCK_PERIODS(8'h02)) DUT (.i_clk_sys(clk), .i_sys_rst(rst),
		.i_converter_clock_input(cin), .i_pll_enable(pll), .i_interp_sel(it), .i_prescale_sel(ps),
		.i_zero_stuff(zs), .o_clk_en(en), .o_rate_clock_or_lock_output(pin), .o_lock_status(lk),
		.o_vco_mult(vco));
	// ====
	// helpers
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t seen %h want %h", $time, seen, exp);
		end
	endtask : check
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction : xs
	task automatic results;
		$display("tests %0d miscompares %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : results
	// ====
	// tests
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 16; i++) begin
			seed = xs(seed);
			@(posedge clk);
			{pll, zs, ps, it} <= seed[5:0];
			repeat (2) @(posedge clk);
			#1 check(vco, 8'(1 << (int'(seed[1:0]) + int'(seed[3:2]) + int'(seed[4]))));
		end
		$display("ratio test done");
		@(posedge clk);
		{pll, zs, ps, it} <= 6'h21;
		run <= 1'b1;
		repeat (40) @(posedge clk);
		#1 check(lk, 1'b1);
		check(pin, 1'b1);
		@(posedge clk);
		// period 2 no longer matches ratio 4, so lock must drop and stay down
		ps <= 2'h1;
		repeat (20) @(posedge clk);
		#1 check(lk, 1'b0);
		$display("lock test done");
		@(posedge clk);
		pll <= 1'b0;
		repeat (10) @(posedge clk);
		cnt = '{default: 8'h00};
		hi = 0;
		repeat (64) begin
			@(posedge clk);
			#1;
			for (int k = 0; k < 4; k++) cnt[k] += 8'(en[k]);
			hi += int'(pin);
		end
		for (int k = 0; k < 4; k++) check(cnt[k], 8'(32 >> (3 - k)));
		check(8'(hi), 8'h20);
		check(lk, 1'b0);
		$display("strobe test done");
		results();
	end
	initial begin
		repeat (3000) @(posedge clk);
		miscompares++;
		results();
	end
endmodule : interpolating_dac_pll_clocking_tb_top
`default_nettype wire
